// >>> rtl/lcp_pkg.sv
// Constants and carrier types for the legacy compatibility and port reset block.
// Assumes a 40 MHz core clock; every user includes nothing and names lcp_pkg:: directly.
`default_nettype none
package lcp_pkg;
  // Port geometry
  localparam int NPORT = 7;
  localparam int PW    = 8;
  localparam int P_C   = 2;
  localparam int P_F   = 5;
  localparam int P_G   = 6;
  // Extended I/O window in data space
  localparam logic [15:0] EXT_IO_LO = 16'h0060;
  localparam logic [15:0] EXT_IO_HI = 16'h00ff;
  // Register map (byte addresses)
  localparam logic [7:0] PORT_END   = 8'h70;
  localparam logic [7:0] OFS_CTRL   = 8'h80;
  localparam logic [7:0] OFS_STAT   = 8'h84;
  localparam logic [7:0] OFS_RSTC   = 8'h88;
  localparam logic [7:0] OFS_ISENSE = 8'h8c;
  localparam logic [1:0] FLD_OUT    = 2'h0;
  localparam logic [1:0] FLD_DIR    = 2'h1;
  localparam logic [1:0] FLD_PU     = 2'h2;
  localparam logic [1:0] FLD_PIN    = 2'h3;
  // Field positions
  localparam int CTRL_ADC  = 0;
  localparam int ST_COMPAT = 0;
  localparam int ST_SPROG  = 1;
  localparam int ST_EXTRST = 2;
  localparam int RC_W      = 5;
  localparam int RC_POR    = 0;
  localparam int RC_EXT    = 1;
  localparam int RC_BOD    = 2;
  localparam int RC_WDT    = 3;
  localparam int RC_JTAG   = 4;
  localparam logic [RC_W-1:0] RC_LEGACY_MASK = 5'h03;
  // Pin images
  localparam logic [PW-1:0] PG_MASK      = 8'h1f;
  localparam logic [PW-1:0] PG_LEGACY_OE = 8'h07;
  localparam logic [PW-1:0] PG_RST_OUT   = 8'h03;
  localparam logic [PW-1:0] JTAG_PINS    = 8'hf0;
  localparam logic [PW-1:0] JTAG_PU      = 8'hb0;
  // External interrupt sense
  localparam int NEXTINT = 8;
  localparam logic [NEXTINT-1:0] LOWLVL_ONLY = 8'hf0;
  localparam logic [1:0] SENSE_LOW = 2'h0;
  // Bus answers
  localparam logic [1:0] RESP_OKAY   = 2'h0;
  localparam logic [1:0] RESP_SLVERR = 2'h2;
  // Reset pin filter timing
  localparam int CLK_NS      = 25;
  localparam int RST_MIN_NS  = 2500;
  localparam int RST_MIN_CYC = (RST_MIN_NS + CLK_NS - 1) / CLK_NS;

  typedef logic [NPORT-1:0][PW-1:0] lcp_bank_t;
  typedef struct packed {
    lcp_bank_t out;
    lcp_bank_t oe;
    lcp_bank_t pu;
  } lcp_pins_t;
  typedef struct packed {
    logic ext_vec_en;
    logic usart1_en;
    logic usart_sync_en;
    logic baud_hi_en;
    logic timer3_en;
    logic ocr_c_en;
    logic twi_en;
    logic boot_en;
    logic osc_cal_en;
    logic xmem_release_en;
    logic xmem_ws_sect_en;
    logic wdt_timed_seq;
    logic rx_fifo_en;
  } lcp_feat_t;
  typedef struct packed {
    logic ext_io_sel;
    logic int_ram_sel;
  } lcp_route_t;
endpackage
`default_nettype wire

// >>> rtl/lcp_top.sv
// Legacy compatibility control, port pin reset behaviour and reset cause flags.
// Assumes an AXI4-Lite master on the register side and pad cells that resolve out/oe/pu.
`default_nettype none
module lcp_top #(
  parameter int ADDR_W = 8
) (
  // Clock and reset
  input  wire  logic                     clk,
  input  wire  logic                     resetn,
  // AXI4-Lite slave
  input  wire  logic [ADDR_W-1:0]        s_axi_awaddr,
  input  wire  logic                     s_axi_awvalid,
  output logic                           s_axi_awready,
  input  wire  logic [31:0]              s_axi_wdata,
  input  wire  logic [3:0]               s_axi_wstrb,
  input  wire  logic                     s_axi_wvalid,
  output logic                           s_axi_wready,
  output logic [1:0]                     s_axi_bresp,
  output logic                           s_axi_bvalid,
  input  wire  logic                     s_axi_bready,
  input  wire  logic [ADDR_W-1:0]        s_axi_araddr,
  input  wire  logic                     s_axi_arvalid,
  output logic                           s_axi_arready,
  output logic [31:0]                    s_axi_rdata,
  output logic [1:0]                     s_axi_rresp,
  output logic                           s_axi_rvalid,
  input  wire  logic                     s_axi_rready,
  // Straps and reset sources
  input  wire  logic                     legacy_compat_fuse,
  input  wire  logic                     rst_pin_n,
  input  wire  logic                     por_active,
  input  wire  logic                     por_evt,
  input  wire  logic                     bod_evt,
  input  wire  logic                     wdt_evt,
  input  wire  logic                     jtag_rst_evt,
  input  wire  logic                     serial_prog_enable_pin,
  // Core data access
  input  wire  logic [15:0]              cpu_addr,
  input  wire  logic                     cpu_ldst,
  input  wire  logic                     cpu_io,
  // Test port and memory strobes
  input  wire  logic                     jtag_en,
  input  wire  logic                     tap_shift,
  input  wire  logic [2:0]               xmem_strobe,
  // Port pads
  input  wire  lcp_pkg::lcp_bank_t       pin_in,
  output wire  lcp_pkg::lcp_pins_t       pins,
  output logic                           tdo_oe,
  // Status to the rest of the chip
  output logic                           compat,
  output lcp_pkg::lcp_route_t            route,
  output lcp_pkg::lcp_feat_t             feat,
  output logic [2*lcp_pkg::NEXTINT-1:0]  isense_eff,
  output logic                           ext_reset_req,
  output logic                           serial_prog_mode
);
  localparam int RW = $clog2(lcp_pkg::RST_MIN_CYC + 1);
  localparam logic [RW-1:0] RST_MIN = RW'(lcp_pkg::RST_MIN_CYC);

  default clocking cb @(posedge clk); endclocking
  default disable iff (!resetn);

  logic                         fuse_taken, next_fuse_taken, next_compat;
  logic [7:0]                   aw_q, next_aw_q, ar_word;
  logic [31:0]                  wd_q, next_wd_q, rd_data, next_rdata;
  logic [3:0]                   ws_q, next_ws_q;
  logic                         aw_full, next_aw_full, w_full, next_w_full;
  logic                         do_wr, wr_ok, rd_ok;
  logic                         next_awready, next_wready, next_bvalid, next_arready, next_rvalid;
  logic [1:0]                   next_bresp, next_rresp;
  lcp_pkg::lcp_bank_t           port_out, port_dir, port_pu, next_port_out, next_port_dir, next_port_pu;
  logic                         adc_in_use, next_adc;
  logic [2*lcp_pkg::NEXTINT-1:0] isense, next_isense, next_isense_eff;
  logic [lcp_pkg::RC_W-1:0]     rc, next_rc, rc_set, rc_clr;
  logic [RW-1:0]                rst_cnt, next_rst_cnt;
  logic                         next_ext_req, next_sprog, next_tdo_oe, cpu_in_ext;
  lcp_pkg::lcp_route_t          next_route;
  lcp_pkg::lcp_feat_t           next_feat;

  function automatic logic addr_ok(input logic [7:0] a);
    logic [7:0] w;
    w = {a[7:2], 2'h0};
    return (w < lcp_pkg::PORT_END) || (w == lcp_pkg::OFS_CTRL) || (w == lcp_pkg::OFS_STAT)
        || (w == lcp_pkg::OFS_RSTC) || (w == lcp_pkg::OFS_ISENSE);
  endfunction

  // Fuse capture: one clocked sample after release, then locked
  always_comb begin
    next_fuse_taken = 1'b1;
    next_compat     = fuse_taken ? compat : legacy_compat_fuse;
  end
  always_ff @(posedge clk or negedge resetn) begin
    if (!resetn) begin
      fuse_taken <= 1'b0;
      compat     <= 1'b0;
    end else begin
      fuse_taken <= next_fuse_taken;
      compat     <= next_compat;
    end
  end

  // AXI4-Lite handshakes; address and data may arrive in either order
  always_comb begin
    next_aw_full = aw_full | (s_axi_awvalid & s_axi_awready);
    next_aw_q    = (s_axi_awvalid & s_axi_awready) ? s_axi_awaddr[7:0] : aw_q;
    next_w_full  = w_full | (s_axi_wvalid & s_axi_wready);
    next_wd_q    = (s_axi_wvalid & s_axi_wready) ? s_axi_wdata : wd_q;
    next_ws_q    = (s_axi_wvalid & s_axi_wready) ? s_axi_wstrb : ws_q;
    do_wr        = aw_full & w_full & ~s_axi_bvalid;
    wr_ok        = addr_ok(aw_q);
    next_bvalid  = s_axi_bvalid & ~s_axi_bready;
    next_bresp   = s_axi_bresp;
    if (do_wr) begin
      next_aw_full = 1'b0;
      next_w_full  = 1'b0;
      next_bvalid  = 1'b1;
      next_bresp   = wr_ok ? lcp_pkg::RESP_OKAY : lcp_pkg::RESP_SLVERR;
    end
    next_awready = ~next_aw_full & ~next_bvalid;
    next_wready  = ~next_w_full & ~next_bvalid;
    next_rvalid  = s_axi_rvalid & ~s_axi_rready;
    next_rdata   = s_axi_rdata;
    next_rresp   = s_axi_rresp;
    if (s_axi_arvalid & s_axi_arready) begin
      next_rvalid = 1'b1;
      next_rdata  = rd_data;
      next_rresp  = rd_ok ? lcp_pkg::RESP_OKAY : lcp_pkg::RESP_SLVERR;
    end
    next_arready = ~next_rvalid;
  end
  always_ff @(posedge clk or negedge resetn) begin
    if (!resetn) begin
      aw_full       <= 1'b0;
      w_full        <= 1'b0;
      aw_q          <= 8'h00;
      wd_q          <= 32'h0000_0000;
      ws_q          <= 4'h0;
      s_axi_awready <= 1'b0;
      s_axi_wready  <= 1'b0;
      s_axi_bvalid  <= 1'b0;
      s_axi_bresp   <= lcp_pkg::RESP_OKAY;
      s_axi_arready <= 1'b0;
      s_axi_rvalid  <= 1'b0;
      s_axi_rdata   <= 32'h0000_0000;
      s_axi_rresp   <= lcp_pkg::RESP_OKAY;
    end else begin
      aw_full       <= next_aw_full;
      w_full        <= next_w_full;
      aw_q          <= next_aw_q;
      wd_q          <= next_wd_q;
      ws_q          <= next_ws_q;
      s_axi_awready <= next_awready;
      s_axi_wready  <= next_wready;
      s_axi_bvalid  <= next_bvalid;
      s_axi_bresp   <= next_bresp;
      s_axi_arready <= next_arready;
      s_axi_rvalid  <= next_rvalid;
      s_axi_rdata   <= next_rdata;
      s_axi_rresp   <= next_rresp;
    end
  end

  // Read mux; undefined bits read zero so legacy code sees clean values
  always_comb begin
    ar_word = {s_axi_araddr[7:2], 2'h0};
    rd_ok   = addr_ok(s_axi_araddr[7:0]);
    rd_data = 32'h0000_0000;
    if (ar_word < lcp_pkg::PORT_END) begin
      unique case (ar_word[3:2])
        lcp_pkg::FLD_OUT: rd_data[7:0] = port_out[ar_word[6:4]];
        lcp_pkg::FLD_DIR: rd_data[7:0] = port_dir[ar_word[6:4]];
        lcp_pkg::FLD_PU:  rd_data[7:0] = port_pu[ar_word[6:4]];
        lcp_pkg::FLD_PIN: rd_data[7:0] = pin_in[ar_word[6:4]];
      endcase
      if (ar_word[6:4] == 3'(lcp_pkg::P_G)) rd_data[7:0] = rd_data[7:0] & lcp_pkg::PG_MASK;
    end else if (ar_word == lcp_pkg::OFS_CTRL) begin
      rd_data[lcp_pkg::CTRL_ADC] = adc_in_use;
    end else if (ar_word == lcp_pkg::OFS_STAT) begin
      rd_data[lcp_pkg::ST_COMPAT] = compat;
      rd_data[lcp_pkg::ST_SPROG]  = serial_prog_mode;
      rd_data[lcp_pkg::ST_EXTRST] = ext_reset_req;
    end else if (ar_word == lcp_pkg::OFS_RSTC) begin
      rd_data[lcp_pkg::RC_W-1:0] = compat ? (rc & lcp_pkg::RC_LEGACY_MASK) : rc;
    end else if (ar_word == lcp_pkg::OFS_ISENSE) begin
      rd_data[2*lcp_pkg::NEXTINT-1:0] = isense;
    end
  end

  // Software registers and reset cause flags; a hardware set beats a clear
  always_comb begin
    next_port_out = port_out;
    next_port_dir = port_dir;
    next_port_pu  = port_pu;
    next_adc      = adc_in_use;
    next_isense   = isense;
    rc_clr        = '0;
    if (do_wr && ws_q[0]) begin
      if (aw_q < lcp_pkg::PORT_END) begin
        unique case (aw_q[3:2])
          lcp_pkg::FLD_OUT: next_port_out[aw_q[6:4]] = wd_q[7:0];
          lcp_pkg::FLD_DIR: next_port_dir[aw_q[6:4]] = wd_q[7:0];
          lcp_pkg::FLD_PU:  next_port_pu[aw_q[6:4]]  = wd_q[7:0];
          lcp_pkg::FLD_PIN: next_port_pu[aw_q[6:4]]  = port_pu[aw_q[6:4]];
        endcase
      end else if ({aw_q[7:2], 2'h0} == lcp_pkg::OFS_CTRL) begin
        next_adc = wd_q[lcp_pkg::CTRL_ADC];
      end else if ({aw_q[7:2], 2'h0} == lcp_pkg::OFS_RSTC) begin
        rc_clr = wd_q[lcp_pkg::RC_W-1:0];
      end else if ({aw_q[7:2], 2'h0} == lcp_pkg::OFS_ISENSE) begin
        next_isense[7:0] = wd_q[7:0];
      end
    end
    if (do_wr && ws_q[1] && {aw_q[7:2], 2'h0} == lcp_pkg::OFS_ISENSE) next_isense[15:8] = wd_q[15:8];
    rc_set                   = '0;
    rc_set[lcp_pkg::RC_POR]  = por_evt;
    rc_set[lcp_pkg::RC_EXT]  = next_ext_req & ~ext_reset_req;
    rc_set[lcp_pkg::RC_BOD]  = bod_evt;
    rc_set[lcp_pkg::RC_WDT]  = wdt_evt;
    rc_set[lcp_pkg::RC_JTAG] = jtag_rst_evt;
    if (compat) rc_set = rc_set & lcp_pkg::RC_LEGACY_MASK;
    next_rc = (rc & ~rc_clr) | rc_set;
  end
  always_ff @(posedge clk or negedge resetn) begin
    if (!resetn) begin
      port_out   <= '0;
      port_dir   <= '0;
      port_pu    <= '0;
      adc_in_use <= 1'b0;
      isense     <= '0;
      rc         <= '0;
    end else begin
      port_out   <= next_port_out;
      port_dir   <= next_port_dir;
      port_pu    <= next_port_pu;
      adc_in_use <= next_adc;
      isense     <= next_isense;
      rc         <= next_rc;
    end
  end

  // Reset pin filter, programming strap, test output enable, feature gating
  always_comb begin
    next_rst_cnt = rst_pin_n ? '0 : ((rst_cnt == RST_MIN) ? rst_cnt : rst_cnt + RW'(1));
    next_ext_req = ~rst_pin_n & (next_rst_cnt == RST_MIN);
    next_sprog   = por_active ? ~serial_prog_enable_pin : serial_prog_mode;
    next_tdo_oe  = jtag_en & tap_shift;
    cpu_in_ext   = (cpu_addr >= lcp_pkg::EXT_IO_LO) && (cpu_addr <= lcp_pkg::EXT_IO_HI);
    next_route.ext_io_sel  = cpu_ldst & cpu_in_ext & ~compat;
    next_route.int_ram_sel = cpu_ldst & cpu_in_ext & compat;
    next_feat    = compat ? '0 : '1;
    for (int i = 0; i < lcp_pkg::NEXTINT; i++) begin
      next_isense_eff[2*i +: 2] = (compat && lcp_pkg::LOWLVL_ONLY[i]) ? lcp_pkg::SENSE_LOW : isense[2*i +: 2];
    end
  end
  always_ff @(posedge clk or negedge resetn) begin
    if (!resetn) begin
      rst_cnt          <= '0;
      ext_reset_req    <= 1'b0;
      serial_prog_mode <= 1'b0;
      tdo_oe           <= 1'b0;
      route            <= '0;
      feat             <= '0;
      isense_eff       <= '0;
    end else begin
      rst_cnt          <= next_rst_cnt;
      ext_reset_req    <= next_ext_req;
      serial_prog_mode <= next_sprog;
      tdo_oe           <= next_tdo_oe;
      route            <= next_route;
      feat             <= next_feat;
      isense_eff       <= next_isense_eff;
    end
  end

  // Per-port pad control; pads follow next_compat so legacy images return on the first clock after release
  for (genvar p = 0; p < lcp_pkg::NPORT; p++) begin : g_port
    logic [lcp_pkg::PW-1:0] oe_q, out_q, pu_q, next_oe, next_out, next_pu, rst_oe, rst_pu;
    always_comb begin
      next_out = port_out[p];
      next_oe  = port_dir[p];
      next_pu  = port_pu[p] & ~port_dir[p];
      rst_oe   = '0;
      rst_pu   = '0;
      if (p == lcp_pkg::P_C) begin
        rst_oe = {lcp_pkg::PW{legacy_compat_fuse}};
        if (next_compat) begin
          next_oe = '1;
          next_pu = '0;
        end
      end
      if (p == lcp_pkg::P_F) begin
        if (next_compat || adc_in_use) next_oe = '0;
        if (adc_in_use) next_pu = '0;
        if (jtag_en) begin
          next_oe = next_oe & ~lcp_pkg::JTAG_PINS;
          next_pu = next_pu | lcp_pkg::JTAG_PU;
          rst_pu  = lcp_pkg::JTAG_PU;
        end
      end
      if (p == lcp_pkg::P_G) begin
        rst_oe = legacy_compat_fuse ? lcp_pkg::PG_LEGACY_OE : '0;
        if (next_compat) begin
          next_oe  = lcp_pkg::PG_LEGACY_OE;
          next_out = {5'h00, xmem_strobe};
          next_pu  = '0;
        end
        next_oe  = next_oe & lcp_pkg::PG_MASK;
        next_out = next_out & lcp_pkg::PG_MASK;
        next_pu  = next_pu & lcp_pkg::PG_MASK;
      end
    end
    // Drive enables drop at once on reset, clock or not
    always_ff @(posedge clk or negedge resetn) begin
      if (!resetn) oe_q <= '0;
      else oe_q <= next_oe;
    end
    if (p == lcp_pkg::P_F) begin : g_pu_img
      always_ff @(posedge clk) begin
        if (!resetn) pu_q <= rst_pu;
        else pu_q <= next_pu;
      end
    end else begin : g_pu_async
      always_ff @(posedge clk or negedge resetn) begin
        if (!resetn) pu_q <= '0;
        else pu_q <= next_pu;
      end
    end
    // Strobe idle levels are safe in normal mode too, since oe is low there
    always_ff @(posedge clk or negedge resetn) begin
      if (!resetn) out_q <= (p == lcp_pkg::P_G) ? lcp_pkg::PG_RST_OUT : '0;
      else out_q <= next_out;
    end
    // The oe reset image bypasses the flop so it needs no clock; the port F pu image loads on a clock edge; the fuse is a static strap, no glitch
    assign pins.oe[p]  = resetn ? oe_q : rst_oe;
    assign pins.out[p] = out_q;
    assign pins.pu[p]  = pu_q;
  end

  // Checks
  property p_io_no_ext; cpu_io && !cpu_ldst |=> !route.ext_io_sel; endproperty
  a_io_no_ext: assert property (p_io_no_ext) else $error("in/out reached extended I/O");
  property p_legacy_ram; compat && cpu_ldst && cpu_in_ext |=> route.int_ram_sel && !route.ext_io_sel; endproperty
  a_legacy_ram: assert property (p_legacy_ram) else $error("legacy window not routed to RAM");
  property p_feat_off; compat ##1 compat |-> feat == '0; endproperty
  a_feat_off: assert property (p_feat_off) else $error("feature left on in legacy mode");
  property p_rc_legacy; compat |-> (rc & ~lcp_pkg::RC_LEGACY_MASK) == '0; endproperty
  a_rc_legacy: assert property (p_rc_legacy) else $error("extra reset flag in legacy mode");
  property p_sense; compat |=> (isense_eff[15:8] == 8'h00); endproperty
  a_sense: assert property (p_sense) else $error("edge sense on low-level-only source");
  property p_port_c; compat |=> pins.oe[lcp_pkg::P_C] == 8'hff; endproperty
  a_port_c: assert property (p_port_c) else $error("port C not output in legacy mode");
  property p_port_f; compat || adc_in_use |=> pins.oe[lcp_pkg::P_F] == 8'h00; endproperty
  a_port_f: assert property (p_port_f) else $error("port F driven while input only");
  property p_tdo; !(jtag_en && tap_shift) |=> !tdo_oe; endproperty
  a_tdo: assert property (p_tdo) else $error("TDO driven outside shift");
  property p_port_g;
    compat |=> pins.oe[lcp_pkg::P_G] == lcp_pkg::PG_LEGACY_OE && pins.out[lcp_pkg::P_G][2:0] == $past(xmem_strobe);
  endproperty
  a_port_g: assert property (p_port_g) else $error("port G not carrying strobes");
  property p_rst_release;
    $rose(resetn) |-> pins.oe[0] == 8'h00 && pins.oe[1] == 8'h00 && pins.out[lcp_pkg::P_G][2:0] == 3'h3;
  endproperty
  a_rst_release: assert property (p_rst_release) else $error("pins not in reset image");
  property p_rst_short; rst_pin_n |=> !ext_reset_req; endproperty
  a_rst_short: assert property (p_rst_short) else $error("reset request without low pin");
  property p_fuse_hold; fuse_taken |=> $stable(compat); endproperty
  a_fuse_hold: assert property (p_fuse_hold) else $error("legacy mode changed while running");
  c_write: cover property (s_axi_bvalid && s_axi_bready);
  c_read: cover property (s_axi_rvalid && s_axi_rready);
  c_ext_rst: cover property ($rose(ext_reset_req));
  c_legacy: cover property (compat && cpu_ldst && cpu_in_ext);
endmodule
`default_nettype wire

// >>> testbench/lcp_board.sv
// Board model for the port pads: drive, pull-up or drift.
// Assumes the block's pin image in and pad levels back out.
`default_nettype none
module lcp_board (
  // Pads
  input  wire lcp_pkg::lcp_pins_t pins,
  output wire lcp_pkg::lcp_bank_t pin_in
);
  timeunit 1ns;
  timeprecision 100ps;
  logic [55:0] v = '0;
  assign pin_in = v;
  // Undriven, unpulled pins flip so a stale level never reads back
  always @(pins)
    v = (pins.oe & pins.out) | (~pins.oe & pins.pu) | (~pins.oe & ~pins.pu & ~v);
endmodule
`default_nettype wire

// >>> testbench/legacy_compat_port_reset_logic_tb.sv
// Directed bench for lcp_top: bus tasks, reset images, mode checks.
// Assumes lcp_board on the pads; all runs end in end_sim.
`default_nettype none
`define CHK(n,e,a) begin comparisons++; if ((a)!==(e)) begin fails++; $display("CHECK FAILED %s exp %h got %h",n,e,a); end end
module legacy_compat_port_reset_logic_tb;
  timeunit 1ns;
  timeprecision 100ps;
  logic clk = 0, resetn = 0, s_axi_awvalid = 0, s_axi_wvalid = 0, s_axi_bready = 0, s_axi_arvalid = 0;
  logic s_axi_rready = 0, legacy_compat_fuse = 0, rst_pin_n = 1, por_active = 0, por_evt = 0, bod_evt = 0;
  logic wdt_evt = 0, jtag_rst_evt = 0, serial_prog_enable_pin = 1, cpu_ldst = 0, cpu_io = 0, jtag_en = 0;
  logic tap_shift = 0;
  logic [7:0] s_axi_awaddr = 0, s_axi_araddr = 0;
  logic [31:0] s_axi_wdata = 0, d;
  logic [3:0] s_axi_wstrb = 4'h3;
  logic [15:0] cpu_addr = 0;
  logic [2:0] xmem_strobe = 3'h5;
  logic [1:0] r;
  wire logic s_axi_awready, s_axi_wready, s_axi_bvalid, s_axi_arready, s_axi_rvalid;
  wire logic tdo_oe, compat, ext_reset_req, serial_prog_mode;
  wire logic [1:0] s_axi_bresp, s_axi_rresp;
  wire logic [31:0] s_axi_rdata;
  wire logic [15:0] isense_eff;
  wire lcp_pkg::lcp_bank_t pin_in;
  wire lcp_pkg::lcp_pins_t pins;
  wire lcp_pkg::lcp_route_t route;
  wire lcp_pkg::lcp_feat_t feat;
  int fails = 0, comparisons = 0;
  lcp_top uut (
    .clk(clk), .resetn(resetn),
    .s_axi_awaddr(s_axi_awaddr), .s_axi_awvalid(s_axi_awvalid), .s_axi_awready(s_axi_awready),
    .s_axi_wdata(s_axi_wdata), .s_axi_wstrb(s_axi_wstrb), .s_axi_wvalid(s_axi_wvalid), .s_axi_wready(s_axi_wready),
    .s_axi_bresp(s_axi_bresp), .s_axi_bvalid(s_axi_bvalid), .s_axi_bready(s_axi_bready),
    .s_axi_araddr(s_axi_araddr), .s_axi_arvalid(s_axi_arvalid), .s_axi_arready(s_axi_arready),
    .s_axi_rdata(s_axi_rdata), .s_axi_rresp(s_axi_rresp), .s_axi_rvalid(s_axi_rvalid), .s_axi_rready(s_axi_rready),
    .legacy_compat_fuse(legacy_compat_fuse), .rst_pin_n(rst_pin_n), .por_active(por_active), .por_evt(por_evt),
    .bod_evt(bod_evt), .wdt_evt(wdt_evt), .jtag_rst_evt(jtag_rst_evt),
    .serial_prog_enable_pin(serial_prog_enable_pin), .cpu_addr(cpu_addr), .cpu_ldst(cpu_ldst), .cpu_io(cpu_io),
    .jtag_en(jtag_en), .tap_shift(tap_shift), .xmem_strobe(xmem_strobe), .pin_in(pin_in), .pins(pins),
    .tdo_oe(tdo_oe), .compat(compat), .route(route), .feat(feat), .isense_eff(isense_eff),
    .ext_reset_req(ext_reset_req), .serial_prog_mode(serial_prog_mode)
  );
  lcp_board board (.pins(pins), .pin_in(pin_in));
  // Clock
  always #12.5 clk = ~clk;
  task automatic wr(input logic [7:0] a, input logic [31:0] w);
    @(posedge clk);
    s_axi_awaddr <= a; s_axi_wdata <= w; s_axi_awvalid <= 1; s_axi_wvalid <= 1; s_axi_bready <= 1;
    do begin
      @(posedge clk);
      if (s_axi_awready) s_axi_awvalid <= 0;
      if (s_axi_wready) s_axi_wvalid <= 0;
    end while (!s_axi_bvalid);
    r = s_axi_bresp; s_axi_bready <= 0;
  endtask
  task automatic rd(input logic [7:0] a);
    @(posedge clk);
    s_axi_araddr <= a; s_axi_arvalid <= 1; s_axi_rready <= 1;
    do begin
      @(posedge clk);
      if (s_axi_arready) s_axi_arvalid <= 0;
    end while (!s_axi_rvalid);
    d = s_axi_rdata; r = s_axi_rresp; s_axi_rready <= 0;
  endtask
  task automatic tick(input int n);
    repeat (n) @(posedge clk);
  endtask
  // Reset with fuse f; pa holds power-on with programming pin low
  task automatic rst(input logic f, input logic pa);
    resetn <= 0; legacy_compat_fuse <= f; por_active <= pa; serial_prog_enable_pin <= ~pa; jtag_en <= 1;
    tick(2);
    `CHK("oe A", 8'h00, pins.oe[0])
    `CHK("oe C", {8{f}}, pins.oe[2])
    `CHK("pu F", 8'hb0, pins.pu[5])
    if (f) `CHK("out G", 8'h03, pins.out[6])
    // Power-on outlasts the reset release by a cycle so the strap is latched
    resetn <= 1; jtag_en <= 0; tick(1);
    por_active <= 0; serial_prog_enable_pin <= 1; tick(1);
    `CHK("compat", f, compat)
    `CHK("sprog", pa, serial_prog_mode)
  endtask
  task automatic end_sim;
    $display("comparisons %0d fails %0d", comparisons, fails);
    if (fails == 0 && comparisons > 0) $display("Finished cleanly");
    else $display("Finished with errors");
    $finish;
  endtask
  // Watchdog well beyond the few hundred cycles of the tests
  initial begin
    #50000;
    fails++;
    end_sim;
  end
  initial begin
    rst(0, 0);
    wr(8'h04, 32'hff); wr(8'h00, 32'ha5);
    `CHK("bresp", lcp_pkg::RESP_OKAY, r)
    tick(1); `CHK("out A", 8'ha5, pins.out[0])
    rd(8'h0c); `CHK("pin A", 32'ha5, d)
    rd(8'h90); `CHK("unmapped", lcp_pkg::RESP_SLVERR, r)
    @(posedge clk) bod_evt <= 1;
    @(posedge clk) bod_evt <= 0;
    rd(8'h88); `CHK("bod flag", 1'b1, d[2])
    cpu_addr <= 16'h0080; cpu_ldst <= 1; tick(2); `CHK("ld/st", 2'b10, route)
    cpu_ldst <= 0; cpu_io <= 1; tick(2); `CHK("in/out", 2'b00, route)
    `CHK("feat", 13'h1fff, feat)
    jtag_en <= 1; tap_shift <= 1; tick(2); `CHK("tdo on", 1'b1, tdo_oe)
    tap_shift <= 0; tick(2); `CHK("tdo off", 1'b0, tdo_oe)
    $display("test normal done");
    rst(1, 1);
    tick(1); `CHK("feat", 13'h0000, feat)
    cpu_io <= 0; cpu_ldst <= 1; tick(2); `CHK("ram", 2'b01, route)
    xmem_strobe <= 3'h2; tick(2); `CHK("strobes", 8'h02, pins.out[6])
    wr(8'h24, 32'h00); wr(8'h54, 32'hff); tick(2);
    `CHK("C out", 8'hff, pins.oe[2])
    `CHK("F in", 8'h00, pins.oe[5])
    @(posedge clk) bod_evt <= 1;
    @(posedge clk) bod_evt <= 0;
    rd(8'h88); `CHK("legacy flags", 3'h0, d[4:2])
    wr(8'h8c, 32'hffff); tick(2); `CHK("low only", 8'h00, isense_eff[15:8])
    `CHK("free sense", 8'hff, isense_eff[7:0])
    $display("test legacy done");
    @(posedge clk) rst_pin_n <= 0;
    tick(98); `CHK("short pulse", 1'b0, ext_reset_req)
    tick(4); `CHK("long pulse", 1'b1, ext_reset_req)
    rst_pin_n <= 1;
    $display("test reset pin done");
    end_sim;
  end
endmodule
`default_nettype wire
